// ---- rtl/drive_io_enable_fault_logic.sv ----
`timescale 1ns/1ns

// Overview of operation
// - Output stage enabled only while hardware enable input is high.
// - Output stage blocked unless safe torque off input is high.
// - Software enable ANDed with hardware enable; may be set permanently.
// - Input eight is fixed to enable and has no function field.
// - Fast inputs one and two resampled in hardware every 2 us.
// - Fast inputs may trigger position latches.
// - Inputs three to seven resampled every 250 us.
// - After reset inputs three to seven have no function, act off.
// - Active polarity of each input follows its selected function.
// - Fault relay mode: closed on no fault, or no fault and enabled.
// - Any fault opens relay and inhibits output stage.
// - Positive set point turns clockwise; direction bit inverts it.
// - No-fault relay mode ignores the output stage enable.
module drive_io_enable_fault_logic #(
  parameter int unsigned SLOW_CYCLES = io_pkg::SLOW_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Field pins, index 0 is input one, index 7 the enable input
  input wire logic [7:0] digitalIn,
  input wire logic safeTorqueOffInput,
  // Drive-internal signals
  input wire logic faultIn,
  input wire logic [31:0] positionIn,
  input wire logic [15:0] setpointIn,
  // Drive outputs
  output logic outputStageEnable,
  output logic faultRelayClose,
  output logic programmableOutputOne,
  output logic programmableOutputTwo,
  output logic [15:0] setpointCmd,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic funcActive(input logic [3:0] f, input logic lvl);
    logic act;
    act = 1'b0;
    unique case (f)
      io_pkg::FN_FAULT_RESET, io_pkg::FN_LATCH, io_pkg::FN_GP_HIGH: act = lvl;
      io_pkg::FN_STOP, io_pkg::FN_GP_LOW: act = ~lvl;
      default: act = 1'b0;
    endcase
    return act;
  endfunction

  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [8:0] syncIn;

  io_sync #(.W(9)) inSync (
    .clk(clk),
    .reset(reset),
    .d({safeTorqueOffInput, digitalIn}),
    .q(syncIn)
  );

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bvalid_r, bvalid_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt, rdata_r, rdata_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic doWrite, arTake;
  logic [io_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [27:0] inFunc_r, inFunc_nxt;
  logic [3:0] outFunc_r, outFunc_nxt;
  logic [io_pkg::INT_W-1:0] intStatus_r, intStatus_nxt, intMask_r, intMask_nxt;
  logic [io_pkg::INT_W-1:0] events;
  logic faultLatched_r, faultLatched_nxt, faultClear;
  logic [31:0] latchOne_r, latchOne_nxt, latchTwo_r, latchTwo_nxt;
  logic [io_pkg::FAST_CNT_W-1:0] fastCnt_r, fastCnt_nxt;
  logic [io_pkg::SLOW_CNT_W-1:0] slowCnt_r, slowCnt_nxt;
  logic fastTick, slowTick;
  logic [1:0] fastIn_r, fastIn_nxt, fastAct_r, fastAct_nxt;
  logic [4:0] slowIn_r, slowIn_nxt;
  logic [6:0] inAct, sampledIn;
  logic stage_r, stage_nxt, relay_r, relay_nxt, outOne_r, outOne_nxt, outTwo_r, outTwo_nxt;
  logic [15:0] setCmd_r, setCmd_nxt;
  logic stopReq, resetReq, gpActive, swEnable;
  logic [31:0] statusWord;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign awready = ~awHeld_r & ~bvalid_r;
  assign wready = ~wHeld_r & ~bvalid_r;
  assign arready = ~rvalid_r;
  assign doWrite = awHeld_r & wHeld_r & ~bvalid_r;
  assign arTake = arvalid & ~rvalid_r;

  // Read data mux, unmapped addresses answer SLVERR
  always_comb
  begin
    statusWord = '0;
    statusWord[io_pkg::ST_INPUTS +: 8] = {syncIn[7], slowIn_r, fastIn_r};
    statusWord[io_pkg::ST_STO] = syncIn[8];
    statusWord[io_pkg::ST_STAGE] = stage_r;
    statusWord[io_pkg::ST_RELAY] = relay_r;
    statusWord[io_pkg::ST_FAULT] = faultLatched_r;
    statusWord[io_pkg::ST_OUT_ONE] = outOne_r;
    statusWord[io_pkg::ST_OUT_TWO] = outTwo_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rvalid_nxt = rvalid_r & ~rready;
    if (arTake)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = io_pkg::RESP_OKAY;
      unique case (araddr)
        io_pkg::OFF_CTRL: rdata_nxt = {28'h0000000, ctrl_r};
        io_pkg::OFF_IN_FUNC: rdata_nxt = {4'h0, inFunc_r};
        io_pkg::OFF_OUT_FUNC: rdata_nxt = {28'h0000000, outFunc_r};
        io_pkg::OFF_STATUS: rdata_nxt = statusWord;
        io_pkg::OFF_INT_STATUS: rdata_nxt = {28'h0000000, intStatus_r};
        io_pkg::OFF_INT_MASK: rdata_nxt = {28'h0000000, intMask_r};
        io_pkg::OFF_LATCH_ONE: rdata_nxt = latchOne_r;
        io_pkg::OFF_LATCH_TWO: rdata_nxt = latchTwo_r;
        default:
        begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = io_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Address and data may arrive in either order; response after both
  always_comb
  begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r & ~bready;
    bresp_nxt = bresp_r;
    if (awvalid & awready)
    begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = awaddr;
    end
    if (wvalid & wready)
    begin
      wHeld_nxt = 1'b1;
      wData_nxt = wdata;
      wStrb_nxt = wstrb;
    end
    if (doWrite)
    begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      unique case (awAddr_r)
        io_pkg::OFF_CTRL, io_pkg::OFF_IN_FUNC, io_pkg::OFF_OUT_FUNC, io_pkg::OFF_STATUS,
        io_pkg::OFF_INT_STATUS, io_pkg::OFF_INT_MASK, io_pkg::OFF_LATCH_ONE,
        io_pkg::OFF_LATCH_TWO: bresp_nxt = io_pkg::RESP_OKAY;
        default: bresp_nxt = io_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= io_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= io_pkg::RESP_OKAY;
    end
    else
    begin
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ----------------------------------------------------------------
  // Sampling and function decode
  // ----------------------------------------------------------------
  assign fastTick = fastCnt_r == io_pkg::FAST_CNT_W'(io_pkg::FAST_CYCLES - 1);
  assign slowTick = slowCnt_r == io_pkg::SLOW_CNT_W'(SLOW_CYCLES - 1);
  // Sampled levels of inputs one to seven, in input order
  assign sampledIn = {slowIn_r, fastIn_r};

  // Per-input activity; a latch code on a slow input counts as off
  always_comb
  begin
    stopReq = 1'b0;
    resetReq = 1'b0;
    gpActive = 1'b0;
    for (int i = 0; i < io_pkg::FUNC_INPUTS; i++)
    begin
      inAct[i] = funcActive(inFunc_r[4*i +: 4], sampledIn[i]);
      if (i >= 2 && inFunc_r[4*i +: 4] == io_pkg::FN_LATCH)
        inAct[i] = 1'b0;
      stopReq = stopReq | (inAct[i] & (inFunc_r[4*i +: 4] == io_pkg::FN_STOP));
      resetReq = resetReq | (inAct[i] & (inFunc_r[4*i +: 4] == io_pkg::FN_FAULT_RESET));
      gpActive = gpActive | (inAct[i] & ((inFunc_r[4*i +: 4] == io_pkg::FN_GP_HIGH) |
        (inFunc_r[4*i +: 4] == io_pkg::FN_GP_LOW)));
    end
  end

  // Fast pair every 2 us, inputs 3..7 every 250 us
  always_comb
  begin
    fastCnt_nxt = fastTick ? '0 : fastCnt_r + 1'b1;
    slowCnt_nxt = slowTick ? '0 : slowCnt_r + 1'b1;
    fastIn_nxt = fastTick ? syncIn[1:0] : fastIn_r;
    slowIn_nxt = slowTick ? syncIn[6:2] : slowIn_r;
    fastAct_nxt = inAct[1:0];
    latchOne_nxt = latchOne_r;
    latchTwo_nxt = latchTwo_r;
    events = '0;
    // Latch on the active edge of a fast input
    if (inFunc_r[3:0] == io_pkg::FN_LATCH && inAct[0] && !fastAct_r[0])
    begin
      latchOne_nxt = positionIn;
      events[io_pkg::INT_LATCH_ONE] = 1'b1;
    end
    if (inFunc_r[7:4] == io_pkg::FN_LATCH && inAct[1] && !fastAct_r[1])
    begin
      latchTwo_nxt = positionIn;
      events[io_pkg::INT_LATCH_TWO] = 1'b1;
    end
    events[io_pkg::INT_FAULT] = faultIn & ~faultLatched_r;
    events[io_pkg::INT_ENABLE_DROP] = stage_r & ~stage_nxt;
  end

  // ----------------------------------------------------------------
  // Enable chain, fault relay, outputs
  // ----------------------------------------------------------------
  assign swEnable = ctrl_r[io_pkg::CTRL_SW_ENABLE] | ctrl_r[io_pkg::CTRL_SW_PERMANENT];
  assign faultClear = (doWrite & (awAddr_r == io_pkg::OFF_CTRL) & wStrb_r[0] &
    wData_r[io_pkg::CTRL_FAULT_CLEAR]) | resetReq;

  always_comb
  begin
    // Input eight is wired straight in, never through a function field
    stage_nxt = syncIn[7] & syncIn[8] & swEnable & ~faultLatched_r & ~faultIn & ~stopReq;
    faultLatched_nxt = faultIn | (faultLatched_r & ~faultClear);
    // Enable plays no part in the plain no-fault mode
    if (ctrl_r[io_pkg::CTRL_RELAY_MODE])
      relay_nxt = ~faultLatched_r & ~faultIn & stage_r;
    else
      relay_nxt = ~faultLatched_r & ~faultIn;
    outOne_nxt = outOne_r;
    outTwo_nxt = outTwo_r;
    if (slowTick)
    begin
      unique case (outFunc_r[1:0])
        io_pkg::OUT_OFF: outOne_nxt = 1'b0;
        io_pkg::OUT_STAGE_ON: outOne_nxt = stage_r;
        io_pkg::OUT_NO_FAULT: outOne_nxt = ~faultLatched_r;
        io_pkg::OUT_GP_ACTIVE: outOne_nxt = gpActive;
      endcase
      unique case (outFunc_r[3:2])
        io_pkg::OUT_OFF: outTwo_nxt = 1'b0;
        io_pkg::OUT_STAGE_ON: outTwo_nxt = stage_r;
        io_pkg::OUT_NO_FAULT: outTwo_nxt = ~faultLatched_r;
        io_pkg::OUT_GP_ACTIVE: outTwo_nxt = gpActive;
      endcase
    end
    // Negating full-scale negative wraps; limit set points upstream
    setCmd_nxt = ctrl_r[io_pkg::CTRL_DIR_INVERT] ? 16'(-setpointIn) : setpointIn;
  end

  // Register writes; hardware set beats a same-cycle clear
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    inFunc_nxt = inFunc_r;
    outFunc_nxt = outFunc_r;
    intMask_nxt = intMask_r;
    intStatus_nxt = intStatus_r;
    if (doWrite)
    begin
      unique case (awAddr_r)
        io_pkg::OFF_CTRL: ctrl_nxt = io_pkg::CTRL_W'(applyStrb({28'h0000000, ctrl_r},
          wData_r, wStrb_r));
        io_pkg::OFF_IN_FUNC: inFunc_nxt = 28'(applyStrb({4'h0, inFunc_r}, wData_r, wStrb_r));
        io_pkg::OFF_OUT_FUNC: outFunc_nxt = 4'(applyStrb({28'h0000000, outFunc_r},
          wData_r, wStrb_r));
        io_pkg::OFF_INT_MASK: intMask_nxt = io_pkg::INT_W'(applyStrb({28'h0000000, intMask_r},
          wData_r, wStrb_r));
        io_pkg::OFF_INT_STATUS:
          if (wStrb_r[0])
            intStatus_nxt = intStatus_r & ~wData_r[io_pkg::INT_W-1:0];
        default: ;
      endcase
    end
    intStatus_nxt = intStatus_nxt | events;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_r <= io_pkg::CTRL_RESET;
      inFunc_r <= io_pkg::IN_FUNC_RESET;
      outFunc_r <= io_pkg::OUT_FUNC_RESET;
      intMask_r <= io_pkg::INT_MASK_RESET;
      intStatus_r <= '0;
      faultLatched_r <= 1'b0;
      latchOne_r <= 32'h00000000;
      latchTwo_r <= 32'h00000000;
      fastCnt_r <= '0;
      slowCnt_r <= '0;
      fastIn_r <= 2'h0;
      slowIn_r <= 5'h00;
      fastAct_r <= 2'h0;
      stage_r <= 1'b0;
      relay_r <= 1'b0;
      outOne_r <= 1'b0;
      outTwo_r <= 1'b0;
      setCmd_r <= 16'h0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      inFunc_r <= inFunc_nxt;
      outFunc_r <= outFunc_nxt;
      intMask_r <= intMask_nxt;
      intStatus_r <= intStatus_nxt;
      faultLatched_r <= faultLatched_nxt;
      latchOne_r <= latchOne_nxt;
      latchTwo_r <= latchTwo_nxt;
      fastCnt_r <= fastCnt_nxt;
      slowCnt_r <= slowCnt_nxt;
      fastIn_r <= fastIn_nxt;
      slowIn_r <= slowIn_nxt;
      fastAct_r <= fastAct_nxt;
      stage_r <= stage_nxt;
      relay_r <= relay_nxt;
      outOne_r <= outOne_nxt;
      outTwo_r <= outTwo_nxt;
      setCmd_r <= setCmd_nxt;
    end
  end

  assign outputStageEnable = stage_r;
  assign faultRelayClose = relay_r;
  assign programmableOutputOne = outOne_r;
  assign programmableOutputTwo = outTwo_r;
  assign setpointCmd = setCmd_r;
  assign irq = |(intStatus_r & intMask_r);

endmodule

// ---- rtl/io_pkg.sv ----
package io_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IN_FUNC = 8'h04;
  localparam logic [7:0] OFF_OUT_FUNC = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_INT_STATUS = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  localparam logic [7:0] OFF_LATCH_ONE = 8'h18;
  localparam logic [7:0] OFF_LATCH_TWO = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SW_ENABLE = 0;
  localparam int CTRL_SW_PERMANENT = 1;
  localparam int CTRL_RELAY_MODE = 2;
  localparam int CTRL_DIR_INVERT = 3;
  localparam int CTRL_FAULT_CLEAR = 4;
  localparam int CTRL_W = 4;
  localparam int FUNC_FIELD_W = 4;
  localparam int FUNC_INPUTS = 7;
  localparam int OUT_FIELD_W = 2;
  localparam int INT_LATCH_ONE = 0;
  localparam int INT_LATCH_TWO = 1;
  localparam int INT_FAULT = 2;
  localparam int INT_ENABLE_DROP = 3;
  localparam int INT_W = 4;
  localparam int ST_INPUTS = 0;
  localparam int ST_STO = 8;
  localparam int ST_STAGE = 9;
  localparam int ST_RELAY = 10;
  localparam int ST_FAULT = 11;
  localparam int ST_OUT_ONE = 12;
  localparam int ST_OUT_TWO = 13;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
  localparam logic [27:0] IN_FUNC_RESET = 28'h0000000;
  localparam logic [3:0] OUT_FUNC_RESET = 4'h0;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Input and output functions
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FN_OFF = 4'h0,
    FN_FAULT_RESET = 4'h1,
    FN_STOP = 4'h2,
    FN_LATCH = 4'h3,
    FN_GP_HIGH = 4'h4,
    FN_GP_LOW = 4'h5
  } infunc_t;

  typedef enum logic [1:0] {
    OUT_OFF = 2'h0,
    OUT_STAGE_ON = 2'h1,
    OUT_NO_FAULT = 2'h2,
    OUT_GP_ACTIVE = 2'h3
  } outfunc_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int FAST_UPDATE_NS = 2000;
  localparam int SLOW_UPDATE_NS = 250000;
  localparam int FAST_CYCLES = FAST_UPDATE_NS / CLK_PERIOD_NS;
  localparam int SLOW_CYCLES = SLOW_UPDATE_NS / CLK_PERIOD_NS;
  localparam int FAST_CNT_W = 8;
  localparam int SLOW_CNT_W = 16;

endpackage

// ---- rtl/io_sync.sv ----
`timescale 1ns/1ns

// Two-flop synchroniser for a vector of unrelated pins
module io_sync #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins and synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ---- testbench/drive_io_checker.sv ----
`timescale 1ns/1ns

// ----------
// Port checker
// ----------
module drive_io_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // Pins and drive signals
  input wire logic [7:0] digitalIn,
  input wire logic safeTorqueOffInput,
  input wire logic faultIn,
  input wire logic [15:0] setpointIn,
  input wire logic outputStageEnable,
  input wire logic faultRelayClose,
  input wire logic [15:0] setpointCmd
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  // Both write channels taken at one edge
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  property p_write_answer;
    s_wr_taken |=> ##1 bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  property p_read_answer;
    s_rd_taken |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data late");
  property p_bresp_stands;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bresp_stands: assert property (p_bresp_stands)
    else $error("write response dropped");
  property p_rdata_stands;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data dropped");
  // Three edges: two synchroniser flops and the stage register
  property p_needs_enable;
    outputStageEnable |-> $past(digitalIn[7], 3);
  endproperty
  a_needs_enable: assert property (p_needs_enable)
    else $error("stage on without enable input");
  property p_needs_sto;
    outputStageEnable |-> $past(safeTorqueOffInput, 3);
  endproperty
  a_needs_sto: assert property (p_needs_sto)
    else $error("stage on without safe torque off input");
  property p_fault_stops;
    faultIn |-> ##2 !outputStageEnable && !faultRelayClose;
  endproperty
  a_fault_stops: assert property (p_fault_stops)
    else $error("fault left stage or relay on");
  property p_relay_open_stage;
    $fell(faultRelayClose) |-> !outputStageEnable;
  endproperty
  a_relay_open_stage: assert property (p_relay_open_stage)
    else $error("relay opened with stage on");
  property p_direction;
    !$past(reset) |-> setpointCmd == $past(setpointIn) || setpointCmd == -$past(setpointIn);
  endproperty
  a_direction: assert property (p_direction)
    else $error("bad set point");
endmodule

bind drive_io_enable_fault_logic drive_io_checker i_chk (.clk, .reset, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .digitalIn, .safeTorqueOffInput, .faultIn, .setpointIn, .outputStageEnable,
  .faultRelayClose, .setpointCmd);

// ---- testbench/field_side.sv ----
`timescale 1ns/1ns

// ----------
// Field switches behind a cable
// ----------
module field_side (
  // Levels wanted by the machine controller
  input wire logic [7:0] pinWant,
  input wire logic stoWant,
  input wire logic slow,
  // Pins into the drive
  output logic [7:0] digitalIn = 8'h00,
  output logic safeTorqueOffInput = 1'b0
);
  // Lag off the clock grid, so pins reach the drive truly unrelated
  always @(pinWant or stoWant)
  begin
    #(slow ? 13 : 3);
    digitalIn = pinWant;
    safeTorqueOffInput = stoWant;
  end
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns

module testbench;
  // ----------
  // Signals
  // ----------
  localparam int SLOW = 50;
  localparam int LIMIT = 20000;
  localparam logic [4:0] S = 5'h01, R = 5'h02, O1 = 5'h04, O2 = 5'h08, I = 5'h10;
  typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} note_t;
  logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic faultIn = 0, hold = 0, stoWant = 0, awready, wready, bvalid, arready, rvalid;
  logic stage, relay, outOne, outTwo, irq, safeTorqueOffInput;
  logic [7:0] awaddr = 0, araddr = 0, pinWant = 0, digitalIn;
  logic [31:0] wdata = 0, positionIn = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [15:0] setpointIn = 0, setpointCmd, spExp;
  logic [1:0] bresp, rresp;
  logic [7:0] offs [5] = '{io_pkg::OFF_CTRL, io_pkg::OFF_IN_FUNC, io_pkg::OFF_OUT_FUNC,
    io_pkg::OFF_INT_STATUS, io_pkg::OFF_INT_MASK};
  int failCount = 0, numChecks = 0, cycles = 0, seed = 32'ha2bd;
  note_t rdQ[$], n;
  logic [1:0] bQ[$];

  always #4 clk = ~clk;

  drive_io_enable_fault_logic #(.SLOW_CYCLES(SLOW)) i_dut (.clk, .reset, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .digitalIn, .safeTorqueOffInput, .faultIn,
    .positionIn, .setpointIn, .outputStageEnable(stage), .faultRelayClose(relay),
    .programmableOutputOne(outOne), .programmableOutputTwo(outTwo), .setpointCmd, .irq);

  field_side i_field (.pinWant(pinWant), .stoWant(stoWant), .slow(cycles[4]),
    .digitalIn(digitalIn), .safeTorqueOffInput(safeTorqueOffInput));

  // ----------
  // Tasks
  // ----------
  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      failCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkResp(input string nm, input logic [1:0] e, input logic [1:0] g);
    chk(nm, {30'h0, e}, {30'h0, g});
  endtask

  // Outputs packed: stage, relay, out one, out two, irq
  task automatic chkOut(input logic [4:0] m, input logic [4:0] e);
    chk("outputs", {27'h0, e & m}, {27'h0, {irq, outTwo, outOne, relay, stage} & m});
  endtask

  task automatic waitc(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic pins(input logic [7:0] p, input logic s);
    pinWant <= p;
    stoWant <= s;
    waitc(6);
  endtask

  // Each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = io_pkg::RESP_OKAY);
    logic ta, tw, da, dw, hb;
    bQ.push_back(r);
    da = 0;
    dw = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge clk);
      ta = awvalid && awready && !da;
      tw = wvalid && wready && !dw;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    // Ready rises a cycle after the response appears, so the response is held one cycle before it is taken
    waitc(2);
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      hb = bvalid;
      @(posedge clk);
    end while (!hb);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic [1:0] r = io_pkg::RESP_OKAY);
    logic ta, hr;
    rdQ.push_back('{e, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(negedge clk);
      ta = arready;
      @(posedge clk);
    end while (!ta);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      hr = rvalid;
      @(posedge clk);
    end while (!hr);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // ----------
  // Monitor, random drive and timeout
  // ----------
  always @(posedge clk)
  begin
    cycles++;
    if (!hold)
    begin
      positionIn <= $random(seed);
      setpointIn <= 16'($random(seed));
    end
    if (rvalid && rready)
    begin
      n = rdQ.pop_front();
      chk("read data", n.v, rdata & n.m);
      chkResp("read resp", n.r, rresp);
    end
    if (bvalid && bready)
      chkResp("write resp", bQ.pop_front(), bresp);
    if (cycles == LIMIT)
    begin
      failCount++;
      summarize();
    end
  end

  // ----------
  // Main sequence
  // ----------
  initial
  begin
    waitc(2);
    reset <= 1'b0;
    @(posedge clk);
    foreach (offs[i]) rd(offs[i], 32'h0, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, io_pkg::RESP_SLVERR);
    wr(8'h20, 32'h1, io_pkg::RESP_SLVERR);
    chkOut(S | R, R);
    // Enable paths one by one
    pins(8'h80, 1'b1);
    wr(io_pkg::OFF_CTRL, 32'h1);
    waitc(4);
    chkOut(S, S);
    pins(8'h80, 1'b0);
    chkOut(S, 5'h0);
    pins(8'h00, 1'b1);
    chkOut(S, 5'h0);
    pins(8'h80, 1'b1);
    wr(io_pkg::OFF_CTRL, 32'h2);
    waitc(4);
    chkOut(S, S);
    // Relay modes
    wr(io_pkg::OFF_CTRL, 32'h6);
    waitc(2);
    chkOut(S | R, S | R);
    pins(8'h00, 1'b1);
    chkOut(S | R, 5'h0);
    wr(io_pkg::OFF_CTRL, 32'h2);
    waitc(2);
    chkOut(R, R);
    // Fault, interrupt mask and clear
    pins(8'h80, 1'b1);
    wr(io_pkg::OFF_INT_MASK, 32'hF);
    faultIn <= 1'b1;
    @(posedge clk);
    faultIn <= 1'b0;
    waitc(3);
    chkOut(S | R | I, I);
    rd(io_pkg::OFF_INT_STATUS, 32'hC, 32'hF);
    wr(io_pkg::OFF_INT_MASK, 32'h0);
    chkOut(I, 5'h0);
    wr(io_pkg::OFF_INT_MASK, 32'hF);
    wr(io_pkg::OFF_INT_STATUS, 32'hC);
    rd(io_pkg::OFF_INT_STATUS, 32'h0, 32'hF);
    chkOut(I, 5'h0);
    wr(io_pkg::OFF_CTRL, 32'h12);
    waitc(3);
    chkOut(S | R, S | R);
    // Slow inputs, polarity by function, slow outputs
    wr(io_pkg::OFF_IN_FUNC, 32'h5400);
    wr(io_pkg::OFF_OUT_FUNC, 32'h7);
    pins(8'h88, 1'b1);
    waitc(2 * SLOW + 10);
    chkOut(O1 | O2, O2);
    pins(8'h8C, 1'b1);
    waitc(2 * SLOW + 10);
    chkOut(O1, O1);
    wr(io_pkg::OFF_IN_FUNC, 32'h25400);
    waitc(2 * SLOW + 10);
    chkOut(S | R | O2, R);
    // Enable input has no function field
    wr(io_pkg::OFF_IN_FUNC, 32'hFFFFFFFF);
    rd(io_pkg::OFF_IN_FUNC, 32'h0FFFFFFF, 32'hFFFFFFFF);
    waitc(2 * SLOW + 10);
    chkOut(S, S);
    // Position latches on both fast inputs
    wr(io_pkg::OFF_IN_FUNC, 32'h33);
    hold <= 1'b1;
    waitc(2);
    for (int i = 0; i < 2; i++)
    begin
      pins(8'h80 | (8'h1 << i), 1'b1);
      waitc(2 * 250 + 10);
      rd(io_pkg::OFF_INT_STATUS, 32'h1 << i, 32'h1 << i);
      rd(io_pkg::OFF_LATCH_ONE + 8'(4 * i), positionIn, 32'hFFFFFFFF);
      pins(8'h80, 1'b1);
    end
    // Set point direction
    for (int d = 0; d < 2; d++)
    begin
      wr(io_pkg::OFF_CTRL, d ? 32'hA : 32'h2);
      waitc(2);
      spExp = d ? 16'(-setpointIn) : setpointIn;
      chk("set point", {16'h0, spExp}, {16'h0, setpointCmd});
    end
    summarize();
  end
endmodule
